// ### pmtic_pkg.sv
// Shared constants, field layout and mode encoding of the transmit capture block
package pmtic_pkg;

    // ------------------------------------------------------------
    // Parallel interface modes, coded as {ddr, speed[1:0]}
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PM_MII10     = 3'b000,
        PM_MII100    = 3'b001,
        PM_GMII      = 3'b010,
        PM_RSVD0     = 3'b011,
        PM_RGMII10   = 3'b100,
        PM_RGMII100  = 3'b101,
        PM_RGMII1000 = 3'b110,
        PM_RSVD1     = 3'b111
    } pmtic_mode_t;

    // ------------------------------------------------------------
    // Clock timing of the core and the generated MII clock
    // ------------------------------------------------------------
    localparam int CORE_CLK_PERIOD_NS = 5;
    localparam int MII100_CLK_PERIOD_NS = 40;
    localparam int MII10_CLK_PERIOD_NS = 400;
    localparam int DIV_W = 6;
    localparam logic [DIV_W-1:0] MII100_HALF_CYC = DIV_W'(MII100_CLK_PERIOD_NS / (2 * CORE_CLK_PERIOD_NS));
    localparam logic [DIV_W-1:0] MII10_HALF_CYC = DIV_W'(MII10_CLK_PERIOD_NS / (2 * CORE_CLK_PERIOD_NS));
    localparam logic [DIV_W-1:0] DIV_CNT_RST = 6'h00;

    // ------------------------------------------------------------
    // Layout of a captured word crossing to the core clock
    // ------------------------------------------------------------
    localparam int WORD_W = 11;
    localparam int WORD_DATA_LSB = 0;
    localparam int WORD_ERR_BIT = 8;
    localparam int WORD_EN_BIT = 9;
    localparam int WORD_NIB_BIT = 10;
    localparam int FIFO_DEPTH_LOG2 = 2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] TX_DATA_RST = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 11'h000;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [3:0] GPIO_OE_B_RST = 4'hf;

endpackage : pmtic_pkg

// ### pmtic_cdc_if.sv
// Word crossing between the link-clock capture and the core clock
`timescale 1ns/1ps
interface pmtic_cdc_if #(
    parameter int WIDTH = 11
);
    logic wrValid;
    logic wrReady;
    logic [WIDTH-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [WIDTH-1:0] rdData;

    modport link (output wrValid, output wrData, input wrReady);
    modport core (output rdReady, input rdValid, input rdData);
    modport fifo (input wrValid, input wrData, input rdReady, output wrReady, output rdValid, output rdData);
endinterface : pmtic_cdc_if

// ### pmtic_cdc_fifo.sv
// Small asynchronous FIFO with gray-coded pointers
`timescale 1ns/1ps
module pmtic_cdc_fifo #(
    parameter int WIDTH = 11,
    parameter int AW = 2
) (
    input wire logic wrClk,
    input wire logic wrRst_b,
    input wire logic rdClk,
    input wire logic rdRst_b,
    pmtic_cdc_if.fifo cdc
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];
    logic [AW:0] wrBin, next_wrBin, wrGray, next_wrGray;
    logic [AW:0] rdBin, next_rdBin, rdGray, next_rdGray;
    logic [AW:0] rdGrayMeta, rdGraySync;
    logic [AW:0] wrGrayMeta, wrGraySync;
    logic doWrite, doRead;

    // ------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------
    assign cdc.wrReady = (wrGray != {~rdGraySync[AW:AW-1], rdGraySync[AW-2:0]});
    assign doWrite = cdc.wrValid & cdc.wrReady;

    // Gray pointer registered so the crossing never sees a glitch
    always_comb begin
        next_wrBin = doWrite ? wrBin + 1'b1 : wrBin;
        next_wrGray = next_wrBin ^ (next_wrBin >> 1);
    end

    always_ff @(posedge wrClk or negedge wrRst_b) begin
        if (!wrRst_b) begin
            wrBin <= '0;
            wrGray <= '0;
            rdGrayMeta <= '0;
            rdGraySync <= '0;
        end else begin
            wrBin <= next_wrBin;
            wrGray <= next_wrGray;
            rdGrayMeta <= rdGray;
            rdGraySync <= rdGrayMeta;
        end
    end

    always_ff @(posedge wrClk) begin
        if (doWrite) begin
            mem[wrBin[AW-1:0]] <= cdc.wrData;
        end
    end

    // ------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------
    assign cdc.rdValid = (rdGray != wrGraySync);
    assign cdc.rdData = mem[rdBin[AW-1:0]];
    assign doRead = cdc.rdValid & cdc.rdReady;

    always_comb begin
        next_rdBin = doRead ? rdBin + 1'b1 : rdBin;
        next_rdGray = next_rdBin ^ (next_rdBin >> 1);
    end

    always_ff @(posedge rdClk or negedge rdRst_b) begin
        if (!rdRst_b) begin
            rdBin <= '0;
            rdGray <= '0;
            wrGrayMeta <= '0;
            wrGraySync <= '0;
        end else begin
            rdBin <= next_rdBin;
            rdGray <= next_rdGray;
            wrGrayMeta <= wrGray;
            wrGraySync <= wrGrayMeta;
        end
    end

endmodule : pmtic_cdc_fifo

// ### pmtic_top.sv
// Transmit-side capture of the parallel MII: GMII, RGMII and MII sampling
`timescale 1ns/1ps
module pmtic_top
    import pmtic_pkg::*;
#(
    parameter int FIFO_AW = FIFO_DEPTH_LOG2
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic gtxClk,
    input wire logic [3:0] txdLo,
    input wire logic [3:0] txdHiIn,
    output logic [3:0] txdHiOut,
    output logic [3:0] txdHiOe_b,
    input wire logic txEnableIn,
    input wire logic txErrorIn,
    input wire logic txClkIn,
    output logic txClkOut,
    output logic txClkOe_b,
    input wire logic ddrSel,
    input wire logic [1:0] speedSel,
    input wire logic clockDirectionSelect,
    input wire logic [3:0] gpioOutValue,
    input wire logic [3:0] gpioDriveEn,
    output logic [3:0] gpioIn,
    output logic gpioAllowed,
    output logic [7:0] txData,
    output logic txNibble,
    output logic txEnable,
    output logic txError,
    output logic txStrobe
);

    pmtic_cdc_if #(.WIDTH(WORD_W)) cdc ();

    // ------------------------------------------------------------
    // Link-domain reset and mode synchronisers
    // ------------------------------------------------------------
    logic linkRstMeta, linkRst_b;
    logic [2:0] linkModeMeta, linkModeSync;
    pmtic_mode_t linkMode;

    always_ff @(posedge gtxClk or negedge rst_b) begin
        if (!rst_b) begin
            linkRstMeta <= 1'b0;
            linkRst_b <= 1'b0;
        end else begin
            linkRstMeta <= 1'b1;
            linkRst_b <= linkRstMeta;
        end
    end

    always_ff @(posedge gtxClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            linkModeMeta <= 3'h0;
            linkModeSync <= 3'h0;
        end else begin
            linkModeMeta <= {ddrSel, speedSel};
            linkModeSync <= linkModeMeta;
        end
    end

    assign linkMode = pmtic_mode_t'(linkModeSync);

    // ------------------------------------------------------------
    // Rising and falling edge samples of the gigabit clock
    // ------------------------------------------------------------
    logic [7:0] riseData, next_riseData;
    logic riseCtl, next_riseCtl;
    logic riseErr, next_riseErr;
    logic [3:0] fallNib, next_fallNib;
    logic fallCtl, next_fallCtl;

    always_comb begin
        next_riseData = {txdHiIn, txdLo};
        next_riseCtl = txEnableIn;
        next_riseErr = txErrorIn;
    end

    always_ff @(posedge gtxClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            riseData <= TX_DATA_RST;
            riseCtl <= 1'b0;
            riseErr <= 1'b0;
        end else begin
            riseData <= next_riseData;
            riseCtl <= next_riseCtl;
            riseErr <= next_riseErr;
        end
    end

    always_comb begin
        next_fallNib = txdLo;
        next_fallCtl = txEnableIn;
    end

    always_ff @(negedge gtxClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            fallNib <= NIB_RST;
            fallCtl <= 1'b0;
        end else begin
            fallNib <= next_fallNib;
            fallCtl <= next_fallCtl;
        end
    end

    // ------------------------------------------------------------
    // Word assembly in the link domain
    // ------------------------------------------------------------
    logic primed, next_primed;
    logic wrValid, next_wrValid;
    logic [WORD_W-1:0] wrWord, next_wrWord;
    logic rgmiiErr;

    // error as XOR of both halves
    assign rgmiiErr = riseCtl ^ fallCtl;

    always_comb begin
        next_primed = 1'b1;
        next_wrValid = 1'b0;
        next_wrWord = WORD_RST;
        case (linkMode)
            PM_GMII: begin
                next_wrValid = primed;
                next_wrWord[WORD_DATA_LSB +: 8] = riseData;
                next_wrWord[WORD_EN_BIT] = riseCtl;
                next_wrWord[WORD_ERR_BIT] = riseErr;
            end
            PM_RGMII1000: begin
                // low nibble then falling high nibble
                next_wrValid = primed;
                next_wrWord[WORD_DATA_LSB +: 8] = {fallNib, riseData[3:0]};
                next_wrWord[WORD_EN_BIT] = riseCtl;
                next_wrWord[WORD_ERR_BIT] = rgmiiErr;
            end
            PM_RGMII10, PM_RGMII100: begin
                next_wrValid = primed;
                next_wrWord[WORD_DATA_LSB +: 4] = riseData[3:0];
                next_wrWord[WORD_NIB_BIT] = 1'b1;
                next_wrWord[WORD_EN_BIT] = riseCtl;
                next_wrWord[WORD_ERR_BIT] = rgmiiErr;
            end
            default: begin
                next_wrValid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge gtxClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            primed <= 1'b0;
            wrValid <= 1'b0;
            wrWord <= WORD_RST;
        end else begin
            primed <= next_primed;
            wrValid <= next_wrValid;
            wrWord <= next_wrWord;
        end
    end

    // Core drains faster than the link fills; a full FIFO drops the word
    assign cdc.wrValid = wrValid;
    assign cdc.wrData = wrWord;

    pmtic_cdc_fifo #(
        .WIDTH(WORD_W),
        .AW(FIFO_AW)
    ) u_cdc_fifo (
        .wrClk(gtxClk),
        .wrRst_b(linkRst_b),
        .rdClk(core_clk),
        .rdRst_b(rst_b),
        .cdc(cdc.fifo)
    );

    // ------------------------------------------------------------
    // Core-domain mode decode and MII clock generator
    // ------------------------------------------------------------
    pmtic_mode_t mode;
    logic miiMode;
    logic miiDce;
    logic [DIV_W-1:0] divCnt, next_divCnt;
    logic divClk, next_divClk;
    logic [DIV_W-1:0] halfCyc;

    assign mode = pmtic_mode_t'({ddrSel, speedSel});
    assign miiMode = (mode == PM_MII10) || (mode == PM_MII100);
    assign miiDce = miiMode && !clockDirectionSelect;
    assign halfCyc = (mode == PM_MII100) ? MII100_HALF_CYC : MII10_HALF_CYC;

    always_comb begin
        next_divCnt = divCnt;
        next_divClk = divClk;
        if (!miiDce) begin
            next_divCnt = DIV_CNT_RST;
            next_divClk = 1'b0;
        end else if (divCnt >= halfCyc - 1'b1) begin
            next_divCnt = DIV_CNT_RST;
            next_divClk = !divClk;
        end else begin
            next_divCnt = divCnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= DIV_CNT_RST;
            divClk <= 1'b0;
            txClkOe_b <= 1'b1;
        end else begin
            divCnt <= next_divCnt;
            divClk <= next_divClk;
            // drive the clock only when select is 0
            txClkOe_b <= !miiDce;
        end
    end

    assign txClkOut = divClk;

    // ------------------------------------------------------------
    // MII sampling in the core domain
    // ------------------------------------------------------------
    logic clkMeta, clkSync, clkPrev;
    logic [5:0] miiMeta, miiSync, miiDly;
    logic miiEdge;

    // Data kept one cycle older than the clock, so the edge sees pre-edge data
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clkMeta <= 1'b0;
            clkSync <= 1'b0;
            clkPrev <= 1'b0;
            miiMeta <= 6'h00;
            miiSync <= 6'h00;
            miiDly <= 6'h00;
        end else begin
            // external clock when select is 1
            clkMeta <= clockDirectionSelect ? txClkIn : divClk;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
            miiMeta <= {txErrorIn, txEnableIn, txdLo};
            miiSync <= miiMeta;
            miiDly <= miiSync;
        end
    end

    assign miiEdge = miiMode && clkSync && !clkPrev;

    // ------------------------------------------------------------
    // Downstream output registers
    // ------------------------------------------------------------
    logic [7:0] next_txData;
    logic next_txNibble, next_txEnable, next_txError, next_txStrobe;

    assign cdc.rdReady = 1'b1;

    always_comb begin
        next_txData = txData;
        next_txNibble = txNibble;
        next_txEnable = txEnable;
        next_txError = txError;
        next_txStrobe = 1'b0;
        if (miiEdge) begin
            next_txData = {4'h0, miiDly[3:0]};
            next_txNibble = 1'b1;
            next_txEnable = miiDly[4];
            next_txError = miiDly[5];
            next_txStrobe = 1'b1;
        end else if (cdc.rdValid) begin
            next_txData = cdc.rdData[WORD_DATA_LSB +: 8];
            next_txNibble = cdc.rdData[WORD_NIB_BIT];
            next_txEnable = cdc.rdData[WORD_EN_BIT];
            next_txError = cdc.rdData[WORD_ERR_BIT];
            next_txStrobe = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            txData <= TX_DATA_RST;
            txNibble <= 1'b0;
            txEnable <= 1'b0;
            txError <= 1'b0;
            txStrobe <= 1'b0;
        end else begin
            txData <= next_txData;
            txNibble <= next_txNibble;
            txEnable <= next_txEnable;
            txError <= next_txError;
            txStrobe <= next_txStrobe;
        end
    end

    // ------------------------------------------------------------
    // Upper data pins as general-purpose I/O
    // ------------------------------------------------------------
    logic [3:0] gpioMeta;
    logic [3:0] next_txdHiOe_b;
    logic next_gpioAllowed;

    always_comb begin
        // no GPIO in GMII or reserved modes
        next_gpioAllowed = miiMode || (mode == PM_RGMII10) || (mode == PM_RGMII100) || (mode == PM_RGMII1000);
        next_txdHiOe_b = next_gpioAllowed ? ~gpioDriveEn : GPIO_OE_B_RST;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpioAllowed <= 1'b0;
            txdHiOe_b <= GPIO_OE_B_RST;
            txdHiOut <= NIB_RST;
            gpioMeta <= NIB_RST;
            gpioIn <= NIB_RST;
        end else begin
            gpioAllowed <= next_gpioAllowed;
            txdHiOe_b <= next_txdHiOe_b;
            txdHiOut <= gpioOutValue;
            gpioMeta <= txdHiIn;
            gpioIn <= gpioMeta;
        end
    end

endmodule : pmtic_top

// ### pmtic_monitor.sv
// Port-level assertion checker for the transmit capture block
`timescale 1ns/1ps
module pmtic_monitor
    import pmtic_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ddrSel,
    input wire logic [1:0] speedSel,
    input wire logic clockDirectionSelect,
    input wire logic [3:0] gpioDriveEn,
    input wire logic txClkIn,
    input wire logic [3:0] txdHiOe_b,
    input wire logic txClkOut,
    input wire logic txClkOe_b,
    input wire logic gpioAllowed,
    input wire logic [7:0] txData,
    input wire logic txNibble,
    input wire logic txStrobe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    logic [2:0] mode;
    logic modeOk;
    logic clkDrive;
    assign mode = {ddrSel, speedSel};
    assign modeOk = speedSel != 2'h3 && mode != 3'h2;
    assign clkDrive = mode[2:1] == 2'h0 && !clockDirectionSelect;

    // Core cycles since the mode last changed, saturating
    logic [2:0] modePrev;
    logic [5:0] modeAge;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            modePrev <= 3'h0;
            modeAge <= 6'h00;
        end else begin
            modePrev <= mode;
            if (mode != modePrev) begin
                modeAge <= 6'h00;
            end else if (modeAge != 6'h3f) begin
                modeAge <= modeAge + 6'h01;
            end
        end
    end

    // Word delivered once link words of the old mode have drained
    sequence s_word;
        txStrobe && modeAge >= 6'h20;
    endsequence
    sequence s_high4;
        txClkOut [*4];
    endsequence

    property p_gmii_byte;
        s_word ##0 mode == 3'h2 |-> !txNibble;
    endproperty
    a_gmii_byte: assert property (p_gmii_byte) else $error("GMII word marked nibble");
    property p_nib_word;
        s_word ##0 (mode inside {3'h0, 3'h1, 3'h4, 3'h5}) |-> txNibble && txData[7:4] == 4'h0;
    endproperty
    a_nib_word: assert property (p_nib_word) else $error("Nibble word malformed");
    property p_ddr_byte;
        s_word ##0 mode == 3'h6 |-> !txNibble;
    endproperty
    a_ddr_byte: assert property (p_ddr_byte) else $error("DDR byte not assembled");
    property p_gpio_allow;
        gpioAllowed == $past(modeOk);
    endproperty
    a_gpio_allow: assert property (p_gpio_allow) else $error("Upper pin use wrong");
    property p_hi_oe;
        $stable(gpioAllowed) |-> txdHiOe_b == (gpioAllowed ? ~$past(gpioDriveEn) : 4'hf);
    endproperty
    a_hi_oe: assert property (p_hi_oe) else $error("Upper pin enable wrong");
    property p_clk_dir;
        txClkOe_b == !$past(clkDrive);
    endproperty
    a_clk_dir: assert property (p_clk_dir) else $error("Clock direction wrong");
    property p_clk_rate;
        $rose(txClkOut) && !txClkOe_b && mode == 3'h1 && $past(mode, 8) == mode |-> s_high4 ##1 !txClkOut;
    endproperty
    a_clk_rate: assert property (p_clk_rate) else $error("Clock half period wrong");
    property p_mii_take;
        $rose(txClkIn) && mode[2:1] == 2'h0 && clockDirectionSelect |-> ##[1:4] txStrobe;
    endproperty
    a_mii_take: assert property (p_mii_take) else $error("MII edge not taken");
endmodule : pmtic_monitor

// ### pmtic_mac_model.sv
// Behavioural MAC driving the transmit pins
`timescale 1ns/1ps
module pmtic_mac_model (
    output logic gtxClk,
    output logic [3:0] txdLo,
    output logic [3:0] txdHi,
    output logic txEnableIn,
    output logic txErrorIn,
    output logic txClkIn
);
    initial begin
        gtxClk = 1'b0;
        txdLo = 4'h0;
        txdHi = 4'h0;
        txEnableIn = 1'b0;
        txErrorIn = 1'b0;
        txClkIn = 1'b0;
    end
    always #15 gtxClk = ~gtxClk;

    task automatic sendGmii(input logic [7:0] d, input logic en, input logic er);
        @(negedge gtxClk);
        {txdHi, txdLo} = d;
        txEnableIn = en;
        txErrorIn = er;
    endtask : sendGmii

    task automatic sendRgmii(input logic [7:0] d, input logic cr, input logic cf);
        @(negedge gtxClk);
        #7.5;
        txdLo = d[3:0];
        txEnableIn = cr;
        txErrorIn = ~txErrorIn;
        @(posedge gtxClk);
        #7.5;
        txdLo = d[7:4];
        txEnableIn = cf;
    endtask : sendRgmii

    // neighbour clock, data changes on fall
    task automatic sendMii(input logic [3:0] n, input logic en, input logic er);
        // Keep pin changes off the core clock edges
        #1;
        txClkIn = 1'b0;
        txdLo = n;
        txEnableIn = en;
        txErrorIn = er;
        #20 txClkIn = 1'b1;
        #19;
    endtask : sendMii
endmodule : pmtic_mac_model

// ### test_pmtic_top.sv
// Self-checking testbench of the transmit capture block
`timescale 1ns/1ps
module test_pmtic_top;
    import pmtic_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b, gtxClk, txEnableIn, txErrorIn, macClk, clkPin;
    logic [3:0] txdLo, macHi, hiPin, txdHiOut, txdHiOe_b, gpioIn;
    logic txClkOut, txClkOe_b, gpioAllowed, txNibble, txEnable, txError, txStrobe;
    logic ddrSel, clockDirectionSelect;
    logic [1:0] speedSel;
    logic [3:0] gpioOutValue, gpioDriveEn;
    logic [7:0] txData;
    logic [10:0] capQ[$];
    int fail_count = 0;
    int compares = 0;

    always #2.5 core_clk = ~core_clk;
    assign hiPin = (txdHiOe_b & macHi) | (~txdHiOe_b & txdHiOut);
    assign clkPin = txClkOe_b ? macClk : txClkOut;

    pmtic_mac_model mac_u (.gtxClk(gtxClk), .txdLo(txdLo), .txdHi(macHi), .txEnableIn(txEnableIn),
        .txErrorIn(txErrorIn), .txClkIn(macClk));
    pmtic_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .gtxClk(gtxClk), .txdLo(txdLo), .txdHiIn(hiPin),
        .txdHiOut(txdHiOut), .txdHiOe_b(txdHiOe_b), .txEnableIn(txEnableIn), .txErrorIn(txErrorIn),
        .txClkIn(clkPin), .txClkOut(txClkOut), .txClkOe_b(txClkOe_b), .ddrSel(ddrSel), .speedSel(speedSel),
        .clockDirectionSelect(clockDirectionSelect), .gpioOutValue(gpioOutValue), .gpioDriveEn(gpioDriveEn),
        .gpioIn(gpioIn), .gpioAllowed(gpioAllowed), .txData(txData), .txNibble(txNibble),
        .txEnable(txEnable), .txError(txError), .txStrobe(txStrobe));

    // Keep only words that carry enable or error
    always @(posedge core_clk) begin
        if (txStrobe === 1'b1 && (txEnable | txError) !== 1'b0) begin
            capQ.push_back({txNibble, txError, txEnable, txData});
        end
    end

    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chkWord(input logic [10:0] exp);
        logic [10:0] got;
        got = 11'hxxx;
        if (capQ.size() > 0) got = capQ.pop_front();
        chk("word", exp, got);
    endtask : chkWord

    task automatic setMode(input logic [2:0] m, input logic dir);
        @(negedge core_clk);
        {ddrSel, speedSel} = m;
        clockDirectionSelect = dir;
        repeat (40) @(posedge core_clk);
        capQ.delete();
    endtask : setMode

    task automatic t_gmii;
        setMode(3'h2, 1'b1);
        mac_u.sendGmii(8'ha5, 1'b1, 1'b0);
        mac_u.sendGmii(8'h3c, 1'b1, 1'b1);
        mac_u.sendGmii(8'hf0, 1'b0, 1'b1);
        mac_u.sendGmii(8'h5a, 1'b0, 1'b0);
        repeat (40) @(posedge core_clk);
        chkWord(11'h1a5);
        chkWord(11'h33c);
        chkWord(11'h2f0);
        chk("hiOe", 11'h00f, {7'h00, txdHiOe_b});
    endtask : t_gmii

    task automatic t_rgmii(input logic [2:0] m);
        logic nib;
        nib = (m != 3'h6);
        setMode(m, 1'b1);
        mac_u.sendRgmii(8'ha5, 1'b1, 1'b1);
        mac_u.sendRgmii(8'hc3, 1'b1, 1'b0);
        mac_u.sendRgmii(8'h7e, 1'b0, 1'b1);
        mac_u.sendRgmii(8'h81, 1'b0, 1'b0);
        repeat (40) @(posedge core_clk);
        chkWord(nib ? 11'h505 : 11'h1a5);
        chkWord(nib ? 11'h703 : 11'h3c3);
        chkWord(nib ? 11'h60e : 11'h27e);
    endtask : t_rgmii

    task automatic t_mii;
        setMode(3'h1, 1'b1);
        mac_u.sendMii(4'h9, 1'b1, 1'b0);
        mac_u.sendMii(4'h6, 1'b1, 1'b1);
        mac_u.sendMii(4'h2, 1'b0, 1'b1);
        mac_u.sendMii(4'hd, 1'b0, 1'b0);
        repeat (10) @(posedge core_clk);
        chkWord(11'h509);
        chkWord(11'h706);
        chkWord(11'h602);
        chk("hiOe", 11'h00c, {7'h00, txdHiOe_b});
        chk("gpioIn", 11'h006, {7'h00, gpioIn});
        chk("clkOe", 11'h001, {10'h000, txClkOe_b});
    endtask : t_mii

    task automatic t_clkout(input logic [2:0] m, input int half);
        int n;
        n = 0;
        setMode(m, 1'b0);
        chk("clkOe", 11'h000, {10'h000, txClkOe_b});
        @(posedge txClkOut);
        @(negedge core_clk);
        while (txClkOut === 1'b1 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        chk("clkHalf", 11'(half), 11'(n));
    endtask : t_clkout

    task automatic t_rsvd;
        setMode(3'h3, 1'b1);
        mac_u.sendGmii(8'ha5, 1'b1, 1'b0);
        mac_u.sendGmii(8'h5a, 1'b0, 1'b0);
        repeat (40) @(posedge core_clk);
        chk("allowed", 11'h000, {10'h000, gpioAllowed});
        chk("rsvdWords", 11'h000, 11'(capQ.size()));
    endtask : t_rsvd

    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst_b = 1'b0;
        ddrSel = 1'b0;
        speedSel = 2'h2;
        clockDirectionSelect = 1'b1;
        gpioOutValue = 4'ha;
        gpioDriveEn = 4'h3;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        chk("rstOe", 11'h00f, {7'h00, txdHiOe_b});
        rst_b = 1'b1;
        t_gmii();
        t_rgmii(3'h4);
        t_rgmii(3'h5);
        t_rgmii(3'h6);
        t_mii();
        t_clkout(3'h1, 4);
        t_clkout(3'h0, 40);
        t_rsvd();
        report_and_stop();
    end

    initial begin
        #50000;
        fail_count++;
        report_and_stop();
    end
endmodule : test_pmtic_top

bind pmtic_top pmtic_monitor mon_u (.core_clk(core_clk), .rst_b(rst_b), .ddrSel(ddrSel), .speedSel(speedSel),
    .clockDirectionSelect(clockDirectionSelect), .gpioDriveEn(gpioDriveEn), .txClkIn(txClkIn),
    .txdHiOe_b(txdHiOe_b), .txClkOut(txClkOut), .txClkOe_b(txClkOe_b), .gpioAllowed(gpioAllowed),
    .txData(txData), .txNibble(txNibble), .txStrobe(txStrobe));
